// File: hw/crcgen_defines.svh
`ifndef CRCGEN_DEFINES_SVH
`define CRCGEN_DEFINES_SVH
// ****************************************
// register offsets
// ****************************************
`define CRCGEN_OFF_CTRL 8'h00
`define CRCGEN_OFF_STATUS 8'h01
`define CRCGEN_OFF_DATA 8'h03
`define CRCGEN_OFF_SUM0 8'h04
`define CRCGEN_OFF_SUM1 8'h05
`define CRCGEN_OFF_SUM2 8'h06
`define CRCGEN_OFF_SUM3 8'h07
`define CRCGEN_OFF_IRQ_STAT 8'h08
`define CRCGEN_OFF_IRQ_CLR 8'h09
`define CRCGEN_OFF_IRQ_EN 8'h0a
// ****************************************
// field positions
// ****************************************
`define CRCGEN_CTRL_PRESET_HI 7
`define CRCGEN_CTRL_PRESET_LO 6
`define CRCGEN_CTRL_WIDE 5
`define CRCGEN_CTRL_SRC_HI 3
`define CRCGEN_CTRL_SRC_LO 0
`define CRCGEN_STAT_BUSY 0
`define CRCGEN_STAT_ZERO 1
`define CRCGEN_EVT_DONE 0
`define CRCGEN_EVT_ZERO 1
// ****************************************
// polynomials, preset codes, reset values
// ****************************************
`define CRCGEN_POLY16 16'h1021
`define CRCGEN_POLY32 32'h04c11db7
`define CRCGEN_PRESET_ZEROS 2'h2
`define CRCGEN_PRESET_ONES 2'h3
`define CRCGEN_SUM_RESET 32'h0000_0000
`define CRCGEN_SRC_RESET 4'h0
`endif

// File: hw/crcgen_pkg.sv
// ****************************************
// shared types
// ****************************************
package crcgen_pkg;
    // generator state, one-hot
    typedef enum logic [1:0] {
        CRCGEN_IDLE = 2'b01,
        CRCGEN_RUN = 2'b10
    } crcgen_state_t;
    // input origin codes of the source field
    typedef enum logic [3:0] {
        CRCGEN_SRC_OFF = 4'h0,
        CRCGEN_SRC_IO = 4'h1,
        CRCGEN_SRC_FLASH = 4'h2,
        CRCGEN_SRC_DMA0 = 4'h4,
        CRCGEN_SRC_DMA1 = 4'h5,
        CRCGEN_SRC_DMA2 = 4'h6,
        CRCGEN_SRC_DMA3 = 4'h7
    } crcgen_src_t;
endpackage

// File: hw/crcgen_core.sv
`timescale 1ns/100ps
`include "crcgen_defines.svh"
module crcgen_core (
    input wire logic sys_clk_in,
    input wire logic nrst_in,
    input wire logic [7:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [7:0] reg_rdata_out,
    input wire logic [7:0] flash_byte_in,
    input wire logic flash_valid_in,
    input wire logic flash_done_in,
    input wire logic [7:0] dma_byte_in,
    input wire logic [3:0] dma_valid_in,
    input wire logic [3:0] dma_done_in,
    output logic busy_out,
    output logic irq_out
);
    // ****************************************
    // byte step of the remainder
    // ****************************************
    // msb of each byte enters first
    function automatic logic [31:0] crcgen_step(
        input logic [31:0] c,
        input logic [7:0] d,
        input logic wide
    );
        logic [31:0] r;
        logic fb;
        r = c;
        fb = 1'b0;
        for (int i = 7; i >= 0; i--) begin
            if (wide) begin
                fb = r[31] ^ d[i];
                r = {r[30:0], 1'b0} ^ (fb ? `CRCGEN_POLY32 : 32'h0);
            end else begin
                fb = r[15] ^ d[i];
                r[15:0] = {r[14:0], 1'b0} ^ (fb ? `CRCGEN_POLY16 : 16'h0);
                r[31:16] = 16'h0;
            end
        end
        return r;
    endfunction

    // end to end bit reversal
    function automatic logic [31:0] crcgen_rev(input logic [31:0] v);
        logic [31:0] r;
        r = 32'h0;
        for (int i = 0; i < 32; i++) begin
            r[i] = v[31 - i];
        end
        return r;
    endfunction

    // ****************************************
    // state
    // ****************************************
    crcgen_pkg::crcgen_state_t state; // idle or running
    crcgen_pkg::crcgen_state_t next_state;
    logic [31:0] sum; // raw remainder
    logic [31:0] next_sum;
    logic [3:0] src; // selected origin
    logic [3:0] next_src;
    logic wide_poly_select; // software width choice
    logic next_wide_poly_select;
    logic zero_flag; // checksum null at completion
    logic next_zero_flag;
    logic [1:0] irq_stat; // sticky events
    logic [1:0] next_irq_stat;
    logic [1:0] irq_en; // event enables
    logic [1:0] next_irq_en;
    logic [7:0] rdata; // registered read answer
    logic [7:0] next_rdata;

    // ****************************************
    // decode helpers
    // ****************************************
    logic running; // generator busy
    logic wide_eff; // width actually in use
    logic [31:0] readout; // checksum as software sees it
    logic [1:0] ch; // dma channel of the origin
    logic src_dma; // origin is a dma channel
    logic wr_ctrl;
    logic wr_stat;
    logic wr_data;
    logic byte_ok; // one byte accepted this cycle
    logic [7:0] byte_sel; // byte being folded in
    logic done; // completion this cycle
    logic [31:0] fin; // remainder after this cycle's byte

    assign running = (state == crcgen_pkg::CRCGEN_RUN);
    // flash always runs wide, whatever software chose for the width
    assign wide_eff = wide_poly_select | (src == crcgen_pkg::CRCGEN_SRC_FLASH);
    assign ch = src[1:0];
    assign src_dma = (src[3:2] == 2'b01);
    assign wr_ctrl = reg_wr_in && (reg_addr_in == `CRCGEN_OFF_CTRL);
    assign wr_stat = reg_wr_in && (reg_addr_in == `CRCGEN_OFF_STATUS);
    assign wr_data = reg_wr_in && (reg_addr_in == `CRCGEN_OFF_DATA);

    // byte selection: only the chosen origin may feed the remainder
    // the dma byte lane is shared, so only the chosen channel's valid counts
    always_comb begin
        byte_ok = 1'b0;
        byte_sel = 8'h00;
        done = 1'b0;
        if (running) begin
            if (src == crcgen_pkg::CRCGEN_SRC_IO) begin
                byte_ok = wr_data;
                byte_sel = reg_wdata_in;
                done = wr_stat && reg_wdata_in[`CRCGEN_STAT_BUSY];
            end else if (src == crcgen_pkg::CRCGEN_SRC_FLASH) begin
                byte_ok = flash_valid_in;
                byte_sel = flash_byte_in;
                done = flash_done_in;
            end else if (src_dma) begin
                byte_ok = dma_valid_in[ch];
                byte_sel = dma_byte_in;
                done = dma_done_in[ch];
            end
        end
    end

    // no accepted byte leaves the remainder untouched
    assign fin = byte_ok ? crcgen_step(sum, byte_sel, wide_eff) : sum;

    // software view of the checksum
    always_comb begin
        if (running && (src == crcgen_pkg::CRCGEN_SRC_FLASH)) begin
            readout = 32'h0; // flash run hides partial result
        end else if (wide_eff && !running) begin
            readout = ~crcgen_rev(sum);
        end else begin
            readout = sum;
        end
    end

    // ****************************************
    // generator next state
    // ****************************************
    always_comb begin
        next_state = state;
        next_sum = fin;
        next_src = src;
        next_wide_poly_select = wide_poly_select;
        next_zero_flag = zero_flag;
        next_irq_stat = irq_stat;
        next_irq_en = irq_en;
        // run state: only a completion or an accepted control write moves it
        case (state)
            crcgen_pkg::CRCGEN_IDLE: begin
                next_state = crcgen_pkg::CRCGEN_IDLE;
            end
            crcgen_pkg::CRCGEN_RUN: begin
                if (done) begin
                    next_state = crcgen_pkg::CRCGEN_IDLE;
                end
            end
            default: begin
                // an illegal one-hot code falls back to idle
                next_state = crcgen_pkg::CRCGEN_IDLE;
            end
        endcase
        // completion closes the run and checks the remainder
        if (done) begin
            next_irq_stat[`CRCGEN_EVT_DONE] = 1'b1;
            if (wide_eff ? (fin == 32'hffff_ffff) : (fin[15:0] == 16'h0)) begin
                next_zero_flag = 1'b1;
                next_irq_stat[`CRCGEN_EVT_ZERO] = 1'b1;
            end
        end
        // control write: origin and width locked while running
        if (wr_ctrl) begin
            if (reg_wdata_in[`CRCGEN_CTRL_PRESET_HI]) begin
                // preset also unlocks the origin
                if (reg_wdata_in[`CRCGEN_CTRL_PRESET_HI:`CRCGEN_CTRL_PRESET_LO]
                        == `CRCGEN_PRESET_ONES) begin
                    next_sum = 32'hffff_ffff;
                end else begin
                    next_sum = 32'h0;
                end
            end
            if (reg_wdata_in[`CRCGEN_CTRL_PRESET_HI] || !running) begin
                next_src = reg_wdata_in[`CRCGEN_CTRL_SRC_HI:`CRCGEN_CTRL_SRC_LO];
                next_wide_poly_select = reg_wdata_in[`CRCGEN_CTRL_WIDE];
                next_zero_flag = 1'b0;
                if (reg_wdata_in[`CRCGEN_CTRL_SRC_HI:`CRCGEN_CTRL_SRC_LO]
                        == crcgen_pkg::CRCGEN_SRC_OFF) begin
                    next_state = crcgen_pkg::CRCGEN_IDLE;
                end else begin
                    next_state = crcgen_pkg::CRCGEN_RUN;
                end
            end
        end
        // checksum bytes writable only while disabled
        if (reg_wr_in && (src == crcgen_pkg::CRCGEN_SRC_OFF) && !wr_ctrl) begin
            if (reg_addr_in == `CRCGEN_OFF_SUM0) begin
                next_sum[7:0] = reg_wdata_in;
            end else if (reg_addr_in == `CRCGEN_OFF_SUM1) begin
                next_sum[15:8] = reg_wdata_in;
            end else if (reg_addr_in == `CRCGEN_OFF_SUM2) begin
                next_sum[23:16] = reg_wdata_in;
            end else if (reg_addr_in == `CRCGEN_OFF_SUM3) begin
                next_sum[31:24] = reg_wdata_in;
            end
        end
        // interrupt clear loses to a fresh event
        if (reg_wr_in && (reg_addr_in == `CRCGEN_OFF_IRQ_CLR)) begin
            next_irq_stat = next_irq_stat & ~(reg_wdata_in[1:0] & ~irq_stat_set(done, fin));
        end
        if (reg_wr_in && (reg_addr_in == `CRCGEN_OFF_IRQ_EN)) begin
            next_irq_en = reg_wdata_in[1:0];
        end
    end

    // events raised this cycle
    function automatic logic [1:0] irq_stat_set(input logic d, input logic [31:0] f);
        logic z;
        z = wide_eff ? (f == 32'hffff_ffff) : (f[15:0] == 16'h0);
        return {d && z, d};
    endfunction

    // registers of the generator
    always_ff @(posedge sys_clk_in) begin
        if (!nrst_in) begin
            state <= crcgen_pkg::CRCGEN_IDLE;
            sum <= `CRCGEN_SUM_RESET;
            src <= `CRCGEN_SRC_RESET;
            wide_poly_select <= 1'b0;
            zero_flag <= 1'b0;
            irq_stat <= 2'h0;
            irq_en <= 2'h0;
        end else begin
            state <= next_state;
            sum <= next_sum;
            src <= next_src;
            wide_poly_select <= next_wide_poly_select;
            zero_flag <= next_zero_flag;
            irq_stat <= next_irq_stat;
            irq_en <= next_irq_en;
        end
    end

    // ****************************************
    // read port
    // ****************************************
    // answer stands one cycle, zero elsewhere
    // write-only and unmapped offsets read back as zero
    always_comb begin
        next_rdata = 8'h00;
        if (reg_rd_in) begin
            if (reg_addr_in == `CRCGEN_OFF_CTRL) begin
                // preset field always reads zero
                next_rdata = {2'b00, wide_poly_select, 1'b0, src};
            end else if (reg_addr_in == `CRCGEN_OFF_STATUS) begin
                next_rdata = {6'h0, zero_flag, running};
            end else if (reg_addr_in == `CRCGEN_OFF_SUM0) begin
                next_rdata = readout[7:0];
            end else if (reg_addr_in == `CRCGEN_OFF_SUM1) begin
                next_rdata = readout[15:8];
            end else if (reg_addr_in == `CRCGEN_OFF_SUM2) begin
                next_rdata = readout[23:16];
            end else if (reg_addr_in == `CRCGEN_OFF_SUM3) begin
                next_rdata = readout[31:24];
            end else if (reg_addr_in == `CRCGEN_OFF_IRQ_STAT) begin
                next_rdata = {6'h0, irq_stat};
            end else if (reg_addr_in == `CRCGEN_OFF_IRQ_EN) begin
                next_rdata = {6'h0, irq_en};
            end
        end
    end

    // read data register
    always_ff @(posedge sys_clk_in) begin
        if (!nrst_in) begin
            rdata <= 8'h00;
        end else begin
            rdata <= next_rdata;
        end
    end

    assign reg_rdata_out = rdata;
    assign busy_out = running;
    assign irq_out = |(irq_stat & irq_en); // level while enabled bit set
endmodule

// File: hw/_unused_guard.sv
`timescale 1ns/100ps

// File: tb/crcgen_assertions.sv
`timescale 1ns/100ps
// ********
// port checker
// ********
module crcgen_checker (
    input wire logic sys_clk_in,
    input wire logic nrst_in,
    input wire logic [7:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    input wire logic [7:0] reg_rdata_out,
    input wire logic flash_done_in,
    input wire logic [3:0] dma_done_in,
    input wire logic busy_out,
    input wire logic irq_out
);
    logic [3:0] src_q; // origin the block runs on
    logic [3:0] next_src_q;
    logic ctl_wr; // control write taken: idle, or a preset forces it
    assign ctl_wr = reg_wr_in && reg_addr_in == 8'h00 && (!busy_out || reg_wdata_in[7]);
    // mirror of the origin field, so no readback is needed
    always_comb begin
        next_src_q = ctl_wr ? reg_wdata_in[3:0] : src_q;
        if (!nrst_in) begin
            next_src_q = 4'h0;
        end
    end
    always_ff @(posedge sys_clk_in) begin
        src_q <= next_src_q;
    end
    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (!nrst_in);
    sequence s_pick; ctl_wr && !busy_out && reg_wdata_in[3:0] != 4'h0; endsequence
    sequence s_io_end;
        busy_out && src_q == 4'h1 && reg_wr_in && reg_addr_in == 8'h01 && reg_wdata_in[0];
    endsequence
    property p_pick; s_pick |=> busy_out; endproperty
    a_pick: assert property (p_pick) else $error("no busy after pick");
    property p_io_end; s_io_end |=> !busy_out; endproperty
    a_io_end: assert property (p_io_end) else $error("io run open");
    property p_dma_end;
        busy_out && src_q[3:2] == 2'h1 && dma_done_in[src_q[1:0]] && !reg_wr_in |=> !busy_out;
    endproperty
    a_dma_end: assert property (p_dma_end) else $error("dma run open");
    property p_fl_end;
        busy_out && src_q == 4'h2 && flash_done_in && !reg_wr_in |=> !busy_out;
    endproperty
    a_fl_end: assert property (p_fl_end) else $error("flash run open");
    property p_fl_hide;
        busy_out && src_q == 4'h2 && !flash_done_in && reg_rd_in && reg_addr_in[7:2] == 6'h01
            |=> reg_rdata_out == 8'h00;
    endproperty
    a_fl_hide: assert property (p_fl_hide) else $error("sum seen in scan");
    property p_quiet; !reg_rd_in |=> reg_rdata_out == 8'h00; endproperty
    a_quiet: assert property (p_quiet) else $error("read data held");
    property p_clr;
        reg_wr_in && reg_addr_in == 8'h09 && reg_wdata_in == 8'hff && !busy_out |=> !irq_out;
    endproperty
    a_clr: assert property (p_clr) else $error("irq after clear");
    property p_ctl_rd;
        reg_rd_in && reg_addr_in == 8'h00 |=> reg_rdata_out[7:6] == 2'h0;
    endproperty
    a_ctl_rd: assert property (p_ctl_rd) else $error("preset field read back");
    property p_rst;
        disable iff (1'b0) !nrst_in |=> !busy_out && !irq_out && reg_rdata_out == 8'h00;
    endproperty
    a_rst: assert property (p_rst) else $error("outputs not reset");
endmodule
bind crcgen_core crcgen_checker u_chk (.sys_clk_in, .nrst_in, .reg_addr_in, .reg_wdata_in,
    .reg_wr_in, .reg_rd_in, .reg_rdata_out, .flash_done_in, .dma_done_in, .busy_out, .irq_out);

// File: tb/crcgen_feeder.sv
`timescale 1ns/100ps
// ********
// byte source: flash scan is ch 8, dma channels 0..3
// ********
module crcgen_feeder (
    input wire logic sys_clk_in,
    output logic [7:0] byte_out,
    output logic flash_valid_out,
    output logic flash_done_out,
    output logic [3:0] dma_valid_out,
    output logic [3:0] dma_done_out
);
    initial begin
        {byte_out, flash_valid_out, flash_done_out, dma_valid_out, dma_done_out} = '0;
    end
    // whole byte each edge; valid stays up so bytes can run back to back
    task automatic send(input int ch, input logic [7:0] b);
        byte_out <= b;
        flash_valid_out <= (ch == 8);
        dma_valid_out <= (ch == 8) ? 4'h0 : 4'h1 << ch;
        @(posedge sys_clk_in);
    endtask
    // release lane, data inverted so nothing stale looks valid; optional end pulse
    task automatic idle(input int n, input int ch);
        byte_out <= ~byte_out;
        flash_valid_out <= 1'b0;
        dma_valid_out <= 4'h0;
        flash_done_out <= (ch == 8);
        dma_done_out <= (ch < 4) ? 4'h1 << ch : 4'h0;
        repeat (n) @(posedge sys_clk_in);
    endtask
endmodule

// File: tb/crc16_wide_poly_select_generator_tb.sv
`timescale 1ns/100ps
// ********
// self-checking bench
// ********
module crc16_wide_poly_select_generator_tb;
    logic sys_clk_in = 1'b0;
    logic nrst_in = 1'b0;
    logic [7:0] reg_addr_in = 8'h00;
    logic [7:0] reg_wdata_in = 8'h00;
    logic reg_wr_in = 1'b0;
    logic reg_rd_in = 1'b0;
    logic [7:0] reg_rdata_out;
    logic [7:0] byte_w; // shared byte lane of the source model
    logic flash_valid_in;
    logic flash_done_in;
    logic [3:0] dma_valid_in;
    logic [3:0] dma_done_in;
    logic busy_out;
    logic irq_out;
    int mismatches = 0;
    int tests_run = 0;
    logic [7:0] q; // last byte read
    logic [1:0] fl; // busy, irq
    logic [31:0] c; // reference remainder
    logic [31:0] s; // checksum read back
    always #20 sys_clk_in = ~sys_clk_in;
    crcgen_core dut (.sys_clk_in, .nrst_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in,
        .reg_rd_in, .reg_rdata_out, .flash_byte_in(byte_w), .flash_valid_in, .flash_done_in,
        .dma_byte_in(byte_w), .dma_valid_in, .dma_done_in, .busy_out, .irq_out);
    crcgen_feeder fd (.sys_clk_in, .byte_out(byte_w), .flash_valid_out(flash_valid_in),
        .flash_done_out(flash_done_in), .dma_valid_out(dma_valid_in), .dma_done_out(dma_done_in));
    // reference step, msb first; narrow keeps the upper half untouched
    function automatic logic [31:0] step(logic [31:0] r, logic [7:0] d, logic w);
        logic fb;
        for (int i = 7; i >= 0; i--) begin
            fb = (w ? r[31] : r[15]) ^ d[i];
            r = w ? {r[30:0], 1'b0} : {r[31:16], r[14:0], 1'b0};
            r = fb ? r ^ (w ? 32'h04c1_1db7 : 32'h0000_1021) : r;
        end
        return r;
    endfunction
    function automatic logic [31:0] flip(logic [31:0] r);
        for (int i = 0; i < 32; i++) begin
            flip[i] = ~r[31 - i];
        end
    endfunction
    task automatic chk(string n, logic [31:0] e, logic [31:0] v);
        tests_run++;
        if (e !== v) begin
            mismatches++;
            $display("BAD %s expected %h seen %h", n, e, v);
        end
    endtask
    // write leaves its strobe up so writes can follow back to back
    task automatic wr(logic [7:0] a, logic [7:0] d);
        reg_addr_in <= a;
        reg_wdata_in <= d;
        reg_wr_in <= 1'b1;
        reg_rd_in <= 1'b0;
        @(posedge sys_clk_in);
    endtask
    task automatic rd(logic [7:0] a);
        reg_addr_in <= a;
        reg_wr_in <= 1'b0;
        reg_rd_in <= 1'b1;
        @(posedge sys_clk_in);
        reg_rd_in <= 1'b0;
        @(negedge sys_clk_in);
        q = reg_rdata_out;
        @(posedge sys_clk_in);
    endtask
    // bus idle one cycle, flags sampled mid-cycle
    task automatic sense();
        reg_wr_in <= 1'b0;
        reg_rd_in <= 1'b0;
        @(negedge sys_clk_in);
        fl = {busy_out, irq_out};
        @(posedge sys_clk_in);
    endtask
    task automatic rsum();
        for (int i = 0; i < 4; i++) begin
            rd(8'h04 + i[7:0]);
            s[8*i +: 8] = q;
        end
    endtask
    task automatic t_reset();
        for (int a = 0; a < 9; a++) begin
            rd(a[7:0]);
            chk("reg", 8'h00, q);
        end
        sense();
        chk("flags", 2'h0, fl);
    endtask
    task automatic t_io();
        for (int w = 0; w < 2; w++) begin
            wr(8'h00, {2'h3, w[0], 5'h01});
            c = 32'hffff_ffff;
            for (int i = 0; i < 4; i++) begin
                wr(8'h03, 8'h31 + i[7:0]);
                c = step(c, 8'h31 + i[7:0], w[0]);
                rd(8'h04);
                chk("running", c[7:0], q);
            end
            wr(8'h01, 8'h01);
            sense();
            chk("busy", 1'b0, fl[1]);
            rsum();
            chk("sum", w ? flip(c) : c[15:0], w ? s : s[15:0]);
        end
    endtask
    task automatic t_irq();
        rd(8'h08);
        chk("events", 8'h01, q);
        wr(8'h0a, 8'h01);
        sense();
        chk("irq", 1'b1, fl[0]);
        wr(8'h0a, 8'h00);
        sense();
        chk("irq masked", 1'b0, fl[0]);
        wr(8'h0a, 8'h01);
        wr(8'h09, 8'hff);
        sense();
        chk("irq cleared", 1'b0, fl[0]);
    endtask
    task automatic t_zero();
        wr(8'h00, 8'h81);
        rd(8'h00);
        chk("ctrl", 8'h01, q);
        wr(8'h03, 8'h00);
        wr(8'h01, 8'h01);
        rd(8'h01);
        chk("status", 8'h02, q);
        rd(8'h08);
        chk("events", 8'h03, q);
        wr(8'h00, 8'h00);
        rd(8'h01);
        chk("status", 8'h00, q);
        // checksum bytes take writes only while no origin is chosen
        wr(8'h04, 8'h5a);
        wr(8'h05, 8'ha5);
        wr(8'h06, 8'h3c);
        wr(8'h07, 8'hc3);
        rsum();
        chk("sum write", 32'hc33c_a55a, s);
    endtask
    // other lanes chatter while a channel runs; only its bytes count
    task automatic t_dma();
        for (int ch = 0; ch < 4; ch++) begin
            wr(8'h00, 8'hc4 + ch[7:0]);
            sense();
            c = 32'hffff_ffff;
            for (int i = 0; i < 3; i++) begin
                fd.send(ch, 8'ha0 + i[7:0]);
                c = step(c, 8'ha0 + i[7:0], 1'b0);
            end
            fd.send((ch + 1) % 4, 8'h5a);
            fd.send(8, 8'h3c);
            fd.idle(2, 9);
            fd.idle(1, ch);
            fd.idle(1, 9);
            sense();
            chk("busy", 1'b0, fl[1]);
            rsum();
            chk("dma sum", c[15:0], s[15:0]);
        end
    endtask
    task automatic t_flash();
        wr(8'h00, 8'hc2);
        rd(8'h04);
        chk("hidden", 8'h00, q);
        c = 32'hffff_ffff;
        for (int i = 0; i < 5; i++) begin
            fd.send(8, 8'h11 * i[7:0]);
            c = step(c, 8'h11 * i[7:0], 1'b1);
        end
        fd.idle(1, 8);
        fd.idle(1, 9);
        rsum();
        chk("flash sum", flip(c), s);
    endtask
    task automatic final_report();
        if (mismatches == 0 && tests_run > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    initial begin
        repeat (12) @(posedge sys_clk_in);
        nrst_in <= 1'b1;
        t_reset();
        t_io();
        t_irq();
        t_zero();
        t_dma();
        t_flash();
        final_report();
    end
    // hang guard
    initial begin
        repeat (20000) @(posedge sys_clk_in);
        mismatches++;
        final_report();
    end
endmodule
